// ===== dsg_consts.svh
// Purpose: offsets, field positions, reset values of the debug-shared gpio port
// Assumes: 32-bit register bus, word offsets as printed
// Notes:   included by the port module; verification repeats the offsets and masks as literals
//
// Behaviour
// - eight pins, each with its own output enable and input enable, so any mix of directions.
// - after reset pin 0 is the debug mode/data pin with input, output and pull-up on.
// - after reset pin 1 is the debug clock pin with input and pull-down on.
// - after reset pins 2 to 7 are plain port pins with input, output and pull-up off.
// - while pin 0 is the debug data pin its driver stays on in stop mode regardless of drive enable.
// - the data register holds bits 7-0, resets to zero, upper bits read zero.
// - the output-control register holds one enable per pin, only bit 0 resets to one.
// - function bits 6..0 route trace data, trace clock, debug clock and debug data; 0 is port.
// - the pull-up register has bits 7-2 and 0, bit 1 reads zero, only bit 0 resets to one.
// - the pull-down register has only bit 1, resetting to one, all else reads zero.
// - registers decode at 0x00, 0x04, 0x08, 0x2c, 0x30 and 0x38.
// - the input-control register has one enable per pin, bits 1 and 0 reset to one.
// - in stop mode with drive enable low, ordinary pins have input and output off.
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH

`define DSG_OFS_DATA    8'h00
`define DSG_OFS_OUTEN   8'h04
`define DSG_OFS_FUNC    8'h08
`define DSG_OFS_PULLUP  8'h2c
`define DSG_OFS_PULLDN  8'h30
`define DSG_OFS_INEN    8'h38

`define DSG_MASK_DATA   8'hff
`define DSG_MASK_OUTEN  8'hff
`define DSG_MASK_FUNC   8'h7f
`define DSG_MASK_PULLUP 8'hfd
`define DSG_MASK_PULLDN 8'h02
`define DSG_MASK_INEN   8'hff

`define DSG_RST_DATA    8'h00
`define DSG_RST_OUTEN   8'h01
`define DSG_RST_FUNC    8'h03
`define DSG_RST_PULLUP  8'h01
`define DSG_RST_PULLDN  8'h02
`define DSG_RST_INEN    8'h03

`define DSG_BIT_DBG_DATA 0
`define DSG_BIT_DBG_CLK  1
`define DSG_BIT_TRC_CLK  2
`define DSG_BIT_TRC_D0   3

`endif

// ===== dsg_pkg.sv
// Purpose: types of the debug-shared gpio port
// Assumes: nothing
// Notes:   constants live in dsg_consts.svh
package dsg_pkg;
  typedef logic [7:0]  dsg_byte_t;
  typedef logic [31:0] dsg_word_t;
endpackage

// ===== dsg_port.sv
// Purpose: eight-pin gpio port shared with the debug interface and trace output
// Assumes: one clock, synchronous active-low reset, plain register port
// Notes:   pad pull controls are levels to the pad ring; pin inputs are synchronised
`timescale 1ns/10ps
`include "dsg_consts.svh"

module dsg_port
  import dsg_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              stop_mode,
  input  wire logic              standby_drive_enable,
  input  wire logic [7:0]        pin_in,
  output logic      [7:0]        pin_out,
  output logic      [7:0]        pin_oe,
  output logic      [7:0]        pin_ie,
  output logic      [7:0]        pin_pullup,
  output logic      [7:0]        pin_pulldown,
  input  wire logic              dbg_data_out,
  input  wire logic              dbg_data_oe,
  output logic                   dbg_data_in,
  output logic                   dbg_clk_in,
  input  wire logic              trace_clk,
  input  wire logic [3:0]        trace_data
);

  // refused at elaboration: a narrower address could never reach the input-control register
  if (ADDR_W < 6) begin : g_addr_w_check
    $error("dsg_port: ADDR_W must reach offset 0x38");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  dsg_byte_t data_r;
  dsg_byte_t outen_r;
  dsg_byte_t func_r;
  dsg_byte_t pullup_r;
  dsg_byte_t pulldn_r;
  dsg_byte_t inen_r;
  dsg_byte_t wbyte;
  logic      sel_data;
  logic      sel_outen;
  logic      sel_func;
  logic      sel_pullup;
  logic      sel_pulldn;
  logic      sel_inen;

  assign wbyte      = reg_wdata[7:0];
  // upper address bits must be zero so aliases never hit
  assign sel_data   = (reg_addr == ADDR_W'(`DSG_OFS_DATA));
  assign sel_outen  = (reg_addr == ADDR_W'(`DSG_OFS_OUTEN));
  assign sel_func   = (reg_addr == ADDR_W'(`DSG_OFS_FUNC));
  assign sel_pullup = (reg_addr == ADDR_W'(`DSG_OFS_PULLUP));
  assign sel_pulldn = (reg_addr == ADDR_W'(`DSG_OFS_PULLDN));
  assign sel_inen   = (reg_addr == ADDR_W'(`DSG_OFS_INEN));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_r <= `DSG_RST_DATA;
    end else if (reg_wr && sel_data) begin
      data_r <= wbyte & `DSG_MASK_DATA;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outen_r <= `DSG_RST_OUTEN;
    end else if (reg_wr && sel_outen) begin
      outen_r <= wbyte & `DSG_MASK_OUTEN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      func_r <= `DSG_RST_FUNC;
    end else if (reg_wr && sel_func) begin
      func_r <= wbyte & `DSG_MASK_FUNC;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pullup_r <= `DSG_RST_PULLUP;
    end else if (reg_wr && sel_pullup) begin
      pullup_r <= wbyte & `DSG_MASK_PULLUP;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulldn_r <= `DSG_RST_PULLDN;
    end else if (reg_wr && sel_pulldn) begin
      pulldn_r <= wbyte & `DSG_MASK_PULLDN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inen_r <= `DSG_RST_INEN;
    end else if (reg_wr && sel_inen) begin
      inen_r <= wbyte & `DSG_MASK_INEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero otherwise

  dsg_byte_t rd_nxt;

  always_comb begin
    rd_nxt = 8'h00;
    unique case (1'b1)
      sel_data:   rd_nxt = data_r;
      sel_outen:  rd_nxt = outen_r;
      sel_func:   rd_nxt = func_r;
      sel_pullup: rd_nxt = pullup_r;
      sel_pulldn: rd_nxt = pulldn_r;
      sel_inen:   rd_nxt = inen_r;
      default:    rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= {24'h00_0000, rd_nxt};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser; stage one is read only by stage two

  dsg_byte_t pin_meta_r;
  dsg_byte_t pin_sync_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad control

  logic      stop_gate;
  dsg_byte_t func_out;
  dsg_byte_t out_data;

  // gating applies only while stopped with drive enable low
  assign stop_gate = stop_mode && !standby_drive_enable;

  always_comb begin
    out_data = data_r;
    func_out = outen_r;
    // debug data pin: direction follows the debug logic, qualified by the enable bit
    if (func_r[`DSG_BIT_DBG_DATA]) begin
      out_data[0] = dbg_data_out;
      func_out[0] = outen_r[0] && dbg_data_oe;
    end
    if (func_r[`DSG_BIT_TRC_CLK]) begin
      out_data[2] = trace_clk;
    end
    for (int i = 0; i < 4; i++) begin
      if (func_r[`DSG_BIT_TRC_D0 + i]) begin
        out_data[3 + i] = trace_data[i];
      end
    end
  end

  always_comb begin
    pin_oe = stop_gate ? 8'h00 : func_out;
    pin_ie = stop_gate ? 8'h00 : inen_r;
    // the debug data pin keeps driving through stop so a debugger survives it
    if (func_r[`DSG_BIT_DBG_DATA]) begin
      pin_oe[0] = func_out[0];
    end
  end

  // the debug clock function has no stop exception: pin_ie[1] is blanked in stop like the rest
  assign pin_out      = out_data;
  assign pin_pullup   = pullup_r;
  assign pin_pulldown = pulldn_r;
  assign dbg_data_in  = func_r[`DSG_BIT_DBG_DATA] && inen_r[0] && pin_sync_r[0];
  assign dbg_clk_in   = func_r[`DSG_BIT_DBG_CLK] && inen_r[1] && pin_sync_r[1];

endmodule

// ===== dsg_port_props.sv
// Purpose: port-level properties of the debug-shared gpio port
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every dsg_port instance
`timescale 1ns/10ps
module dsg_port_props #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  input wire logic              stop_mode,
  input wire logic              standby_drive_enable,
  input wire logic [7:0]        pin_oe,
  input wire logic [7:0]        pin_ie,
  input wire logic [7:0]        pin_pullup,
  input wire logic [7:0]        pin_pulldown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic gate;
  // stop with drive enable low blanks ordinary pins
  assign gate = stop_mode && !standby_drive_enable;
  ////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read reply");
  AST_RD_UPPER: assert property (reg_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_PULL_HOLES: assert property (
    !pin_pullup[1] && pin_pulldown[7:2] == 6'h0 && !pin_pulldown[0])
    else $error("pull enable on an unimplemented bit");
  AST_RST_PINS: assert property (
    !$past(rst_n) |-> pin_pullup == 8'h01 && pin_pulldown == 8'h02
    && pin_oe[7:1] == 7'h0 && pin_ie == (gate ? 8'h00 : 8'h03))
    else $error("pin controls wrong after reset");
  AST_STOP_GATE: assert property (gate |-> pin_ie == 8'h00 && pin_oe[7:1] == 7'h0)
    else $error("pins enabled in stop with drive enable low");
  AST_OE_WR: assert property (
    $past(reg_wr) && $past(reg_addr) == 'h04 && $past(rst_n) && !gate
    |-> pin_oe[7:1] == $past(reg_wdata[7:1]))
    else $error("output enables do not follow write");
  AST_IE_WR: assert property (
    $past(reg_wr) && $past(reg_addr) == 'h38 && $past(rst_n) && !gate
    |-> pin_ie == $past(reg_wdata[7:0]))
    else $error("input enables do not follow write");
  AST_PU_WR: assert property (
    $past(reg_wr) && $past(reg_addr) == 'h2c && $past(rst_n)
    |-> pin_pullup == ($past(reg_wdata[7:0]) & 8'hfd))
    else $error("pull-ups do not follow write");
  AST_PD_WR: assert property (
    $past(reg_wr) && $past(reg_addr) == 'h30 && $past(rst_n)
    |-> pin_pulldown == ($past(reg_wdata[7:0]) & 8'h02))
    else $error("pull-down does not follow write");
  cover property (gate);
  cover property (reg_rd ##1 reg_rdata != 32'h0);
  cover property (stop_mode && standby_drive_enable && pin_ie != 8'h00);
endmodule
bind dsg_port dsg_port_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .stop_mode(stop_mode), .standby_drive_enable(standby_drive_enable),
  .pin_oe(pin_oe), .pin_ie(pin_ie), .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown));

// ===== dsg_pins_model.sv
// Purpose: pad ring and board beside the port
// Assumes: bench never drives a pin the port drives
// Notes:   a floating pad toggles so a stale level never passes
`timescale 1ns/10ps
module dsg_pins_model (
  input wire logic       clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_pulldown,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic     [7:0] pin_in
);
  logic [7:0] float_r = 8'h55;
  always @(posedge clk) float_r <= ~float_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup[i] || pin_pulldown[i]) pin_in[i] = pin_pullup[i];
      else pin_in[i] = float_r[i];
    end
  end
endmodule

// ===== dsg_port_tb.sv
// Purpose: self-checking bench for the debug-shared gpio port
// Assumes: pads resolved by dsg_pins_model
// Notes:   rows give address, reset value, write data, read-back
`timescale 1ns/10ps
module dsg_port_tb;
  typedef struct {logic [7:0] a; logic [31:0] r; logic [31:0] d; logic [31:0] e;} dsg_row_s;
  dsg_row_s   rows [7] = '{'{8'h00, 32'h00, 32'hffff_ffff, 32'hff},
    '{8'h04, 32'h01, 32'h0000_01aa, 32'haa}, '{8'h08, 32'h03, 32'hffff_ffff, 32'h7f},
    '{8'h2c, 32'h01, 32'hffff_ffff, 32'hfd}, '{8'h30, 32'h02, 32'hffff_ffff, 32'h02},
    '{8'h38, 32'h03, 32'h0000_005a, 32'h5a}, '{8'h3c, 32'h00, 32'hffff_ffff, 32'h00}};
  logic       clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0;
  logic       sde = 1'b0, dbg_out = 1'b1, dbg_oe = 1'b1, trc_clk = 1'b1;
  logic [3:0] trc_data = 4'ha;
  logic [7:0] reg_addr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] pin_in, pin_out, pin_oe, pin_ie, pin_pu, pin_pd;
  logic       dbg_in, dbg_clk_in;
  int         miscompares = 0, num_checks = 0;
  always #4 clk = ~clk;
  dsg_port u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .stop_mode(stop_mode),
    .standby_drive_enable(sde), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_ie(pin_ie), .pin_pullup(pin_pu), .pin_pulldown(pin_pd), .dbg_data_out(dbg_out),
    .dbg_data_oe(dbg_oe), .dbg_data_in(dbg_in), .dbg_clk_in(dbg_clk_in),
    .trace_clk(trc_clk), .trace_data(trc_data));
  dsg_pins_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .pin_pulldown(pin_pd), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic md(input logic s, input logic e);
    @(posedge clk);
    stop_mode <= s;
    sde <= e;
    #1;
  endtask
  task automatic results();
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(pin_pu, 8'h01);
    chk(pin_pd, 8'h02);
    chk({pin_ie, pin_oe}, 16'h0301);
    foreach (rows[i]) rd(rows[i].a, rows[i].r);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    chk(pin_out & 8'hfd, 8'hd5);
    wr(8'h04, 32'hff);
    wr(8'h38, 32'hff);
    md(1'b1, 1'b0);
    chk({pin_oe, pin_ie}, 16'h0100);
    @(posedge clk);
    dbg_oe <= 1'b0;
    #1 chk(pin_oe, 8'h00);
    @(posedge clk);
    dbg_oe <= 1'b1;
    md(1'b1, 1'b1);
    chk({pin_oe, pin_ie}, 16'hffff);
    md(1'b1, 1'b0);
    wr(8'h08, 32'h00);
    chk(pin_oe, 8'h00);
    md(1'b0, 1'b0);
    wr(8'h00, 32'ha5);
    chk(pin_out, 8'ha5);
    wr(8'h04, 32'h00);
    wr(8'h08, 32'h03);
    ext_en <= 8'h03;
    ext_val <= 8'h03;
    repeat (3) @(posedge clk);
    #1 chk({dbg_in, dbg_clk_in}, 2'h3);
    wr(8'h08, 32'h00);
    chk({dbg_in, dbg_clk_in}, 2'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h08, 32'h03);
    results();
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
